// file: src/adcrc_pkg.sv
// package: offsets, field positions, reset values and timing of the converter control block
package adcrc_pkg;

   // cpu byte addresses (upper byte of a result at the even address)
   localparam logic [3:0] ADDR_RES_A_HI = 4'h0;
   localparam logic [3:0] ADDR_RES_D_LO = 4'h7;
   localparam logic [3:0] ADDR_CSR      = 4'h8;
   localparam logic [3:0] ADDR_TRG_CTRL = 4'h9;

   // conv_control_status field positions
   localparam int CSR_END_FLAG  = 7;
   localparam int CSR_IRQ_EN    = 6;
   localparam int CSR_START     = 5;
   localparam int CSR_SCAN      = 4;
   localparam int CSR_TIME_SEL  = 3;

   // conv_trigger_control field positions and fixed bits
   localparam int         TRG_ENABLE     = 7;
   localparam int         TRG_SPARE      = 0;
   localparam logic [7:0] TRG_FIXED_ONES = 8'h7E;

   localparam logic [7:0] CSR_RESET = 8'h00;
   localparam logic [9:0] RES_RESET = 10'h000;

   // timing: one state is one system clock
   localparam int STATE_NS          = 10;
   localparam int CLK_NS            = 10;
   localparam int FIRST_SLOW_STATES = 134;
   localparam int FIRST_FAST_STATES = 70;
   localparam int NEXT_SLOW_STATES  = 128;
   localparam int NEXT_FAST_STATES  = 66;
   localparam logic [7:0] FIRST_SLOW_CYC = 8'((FIRST_SLOW_STATES * STATE_NS) / CLK_NS);
   localparam logic [7:0] FIRST_FAST_CYC = 8'((FIRST_FAST_STATES * STATE_NS) / CLK_NS);
   localparam logic [7:0] NEXT_SLOW_CYC  = 8'((NEXT_SLOW_STATES * STATE_NS) / CLK_NS);
   localparam logic [7:0] NEXT_FAST_CYC  = 8'((NEXT_FAST_STATES * STATE_NS) / CLK_NS);

   typedef enum logic [1:0]
   {
      ADCRC_IDLE = 2'b01,
      ADCRC_CONV = 2'b10
   } adcrc_state_t;

   // cpu request
   typedef struct packed
   {
      logic       rd;
      logic       wr;
      logic       word;
      logic [3:0] addr;
      logic [7:0] wdata;
   } adcrc_cpu_req_t;

   // cpu answer
   typedef struct packed
   {
      logic        rvalid;
      logic [15:0] rdata;
   } adcrc_cpu_rsp_t;

   // whole block state
   typedef struct packed
   {
      adcrc_state_t   state;
      logic [7:0]     csr;
      logic           flag_seen;
      logic           trg_en;
      logic           trg_spare;
      logic           trg_prev;
      logic [3:0][9:0] res;
      logic [7:0]     lo_latch;
      logic [2:0]     chan;
      logic [7:0]     cnt;
      logic           sample;
      logic           irq;
      adcrc_cpu_rsp_t rsp;
   } adcrc_regs_t;

endpackage

// file: src/adcrc_top.sv
// converter result registers, control/status register and conversion sequencer
//
// Functional notes
// [RULE_01] four read-only 16-bit result registers, one per channel position
// [RULE_02] 10-bit result sits in bits 15..6, low six bits read zero
// [RULE_03] upper byte read directly, lower byte copied to latch then
// [RULE_04] software reads upper byte first, then lower byte, for coherence
// [RULE_05] a word read returns the whole result in one access
// [RULE_06] reset clears every result register to zero
// [RULE_07] inputs 4..7 land in result registers A..D
// [RULE_08] inputs 0..3 land in A..D too; two low channel bits choose
// [RULE_09] end flag set at single end or after last scanned channel
// [RULE_10] end flag cleared only by writing 0 after reading it as 1
// [RULE_11] interrupt request while end flag and interrupt enable both set
// [RULE_12] writing 1 to start begins; single mode clears start when done
// [RULE_13] scan repeats until start cleared by software, reset or standby
// [RULE_14] mode bit: 0 single channel, 1 repeated scan
// [RULE_15] time select: 134 states when 0, 70 states when 1
// [RULE_16] software clears start before changing time select
// [RULE_17] channel bits pick one input, or group and last scanned channel
// [RULE_18] software clears start before changing mode or channel
// [RULE_19] later scan conversions take 128 or 66 states
// [RULE_20] enabled trigger edge sets start, then acts as software start
// [RULE_21] each result stored no later than its end flag
`timescale 1ns/10ps
module adcrc_top
(
   // clock and reset
   input  wire logic                     clk_i,
   input  wire logic                     rst_i,
   // cpu byte bus
   input  wire adcrc_pkg::adcrc_cpu_req_t cpu_req_i,
   output      adcrc_pkg::adcrc_cpu_rsp_t cpu_rsp_o,
   // converter core
   input  wire logic [9:0]               core_result_i,
   output      logic [2:0]               core_chan_o,
   output      logic                     core_sample_o,
   output      logic                     conv_busy_o,
   // system
   input  wire logic                     standby_i,
   input  wire logic                     ext_trigger_input_i,
   input  wire logic                     ext_trigger_rising_i,
   output      logic                     conv_end_irq_o
);
   import adcrc_pkg::*;

   adcrc_regs_t r_q;
   adcrc_regs_t r_d;

   ////////////////////////////////////////////////////////////////////////////

   always_comb
   begin
      logic        rd_csr;
      logic        wr_csr;
      logic        trg_edge;
      logic        last;
      logic        set_flag;
      logic [1:0]  idx;
      logic [15:0] full;
      logic [7:0]  byte_v;

      r_d      = r_q;
      trg_edge = 1'b0;
      set_flag = 1'b0;
      last     = 1'b0;
      idx      = cpu_req_i.addr[2:1];
      full     = {r_q.res[idx], 6'h00};                               // [RULE_02]
      byte_v   = 8'h00;
      rd_csr   = cpu_req_i.rd && (cpu_req_i.addr == ADDR_CSR);
      wr_csr   = cpu_req_i.wr && (cpu_req_i.addr == ADDR_CSR);
      r_d.sample   = 1'b0;
      r_d.rsp      = '0;
      r_d.trg_prev = ext_trigger_input_i;

      // cpu reads: results are read only, writes to them are ignored    [RULE_01]
      if (cpu_req_i.rd)
      begin
         r_d.rsp.rvalid = 1'b1;
         if (cpu_req_i.addr <= ADDR_RES_D_LO)
         begin
            if (cpu_req_i.word)
               r_d.rsp.rdata = full;                                  // [RULE_05]
            else if (!cpu_req_i.addr[0])
            begin
               byte_v       = full[15:8];
               r_d.lo_latch = full[7:0];                              // [RULE_03]
            end
            else
               byte_v = r_q.lo_latch;                                 // [RULE_03]
         end
         else if (cpu_req_i.addr == ADDR_CSR)
            byte_v = r_q.csr;
         else if (cpu_req_i.addr == ADDR_TRG_CTRL)
            byte_v = TRG_FIXED_ONES | {r_q.trg_en, 6'h00, r_q.trg_spare};
         if (!cpu_req_i.word)
            r_d.rsp.rdata = {8'h00, byte_v};
      end

      if (rd_csr && r_q.csr[CSR_END_FLAG])
         r_d.flag_seen = 1'b1;

      // control writes; the end flag bit only accepts a clearing 0
      if (wr_csr)
      begin
         r_d.csr[6:0] = cpu_req_i.wdata[6:0];                         // [RULE_14] [RULE_15] [RULE_17]
         if (!cpu_req_i.wdata[CSR_END_FLAG] && r_q.flag_seen)
         begin
            r_d.csr[CSR_END_FLAG] = 1'b0;                             // [RULE_10]
            r_d.flag_seen         = 1'b0;
         end
      end
      if (cpu_req_i.wr && (cpu_req_i.addr == ADDR_TRG_CTRL))
      begin
         r_d.trg_en    = cpu_req_i.wdata[TRG_ENABLE];
         r_d.trg_spare = cpu_req_i.wdata[TRG_SPARE];
      end

      // external trigger on the chosen edge sets the start bit
      trg_edge = ext_trigger_rising_i ? (ext_trigger_input_i && !r_q.trg_prev)
                                      : (!ext_trigger_input_i && r_q.trg_prev);
      if (r_q.trg_en && trg_edge)
         r_d.csr[CSR_START] = 1'b1;                                   // [RULE_20]

      if (standby_i)
         r_d.csr[CSR_START] = 1'b0;                                   // [RULE_13]

      case (r_q.state)
         ADCRC_IDLE:
         begin
            if (r_q.csr[CSR_START] && !standby_i)
            begin
               r_d.state  = ADCRC_CONV;
               r_d.chan   = r_q.csr[CSR_SCAN] ? {r_q.csr[2], 2'b00} : r_q.csr[2:0]; // [RULE_17]
               r_d.cnt    = r_q.csr[CSR_TIME_SEL] ? FIRST_FAST_CYC : FIRST_SLOW_CYC; // [RULE_15]
               r_d.sample = 1'b1;
            end
         end
         ADCRC_CONV:
         begin
            // start cleared by software or standby stops the sequence at once
            if (!r_d.csr[CSR_START])
               r_d.state = ADCRC_IDLE;                                // [RULE_13]
            else if (r_q.cnt != 8'h01)
               r_d.cnt = r_q.cnt - 8'h01;
            else
            begin
               r_d.res[r_q.chan[1:0]] = core_result_i;                // [RULE_07] [RULE_08] [RULE_21]
               if (!r_q.csr[CSR_SCAN])
               begin
                  set_flag           = 1'b1;                          // [RULE_09]
                  r_d.csr[CSR_START] = 1'b0;                          // [RULE_12]
                  r_d.state          = ADCRC_IDLE;
               end
               else
               begin
                  last       = (r_q.chan[1:0] == r_q.csr[1:0]);
                  set_flag   = last;                                  // [RULE_09]
                  r_d.chan   = last ? {r_q.chan[2], 2'b00}
                                    : {r_q.chan[2], r_q.chan[1:0] + 2'b01}; // [RULE_14]
                  r_d.cnt    = r_q.csr[CSR_TIME_SEL] ? NEXT_FAST_CYC : NEXT_SLOW_CYC; // [RULE_19]
                  r_d.sample = 1'b1;
               end
            end
         end
         default:
            r_d.state = ADCRC_IDLE;
      endcase

      // a finishing conversion beats a clearing write in the same cycle
      if (set_flag)
         r_d.csr[CSR_END_FLAG] = 1'b1;                                // [RULE_09]

      r_d.irq = r_d.csr[CSR_END_FLAG] && r_d.csr[CSR_IRQ_EN];         // [RULE_11]
   end

   ////////////////////////////////////////////////////////////////////////////

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         r_q           <= '0;
         r_q.state     <= ADCRC_IDLE;
         r_q.csr       <= CSR_RESET;
         r_q.res       <= {4{RES_RESET}};                             // [RULE_06]
         r_q.trg_prev  <= 1'b1;
      end
      else
         r_q <= r_d;
   end

   ////////////////////////////////////////////////////////////////////////////

   assign cpu_rsp_o      = r_q.rsp;
   assign core_chan_o    = r_q.chan;
   assign core_sample_o  = r_q.sample;
   // one-hot code: the conversion state bit is the busy flop itself
   assign conv_busy_o    = r_q.state[1];
   assign conv_end_irq_o = r_q.irq;

endmodule

// file: tb/adcrc_sva.sv
// checker: bus answers, conversion length and interrupt causes
`timescale 1ns/10ps
module adcrc_sva
(
   // watched ports
   input wire logic                      clk_i,
   input wire logic                      rst_i,
   input wire adcrc_pkg::adcrc_cpu_req_t cpu_req_i,
   input wire adcrc_pkg::adcrc_cpu_rsp_t cpu_rsp_o,
   input wire logic [2:0]                core_chan_o,
   input wire logic                      core_sample_o,
   input wire logic                      conv_busy_o,
   input wire logic                      standby_i,
   input wire logic                      conv_end_irq_o
);
   import adcrc_pkg::*;
   adcrc_cpu_req_t req_q;
   logic [7:0]     len_q;
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         req_q <= '0;
         len_q <= 8'h00;
      end
      else
      begin
         req_q <= cpu_req_i;
         len_q <= conv_busy_o ? len_q + 8'h01 : 8'h00;
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   ////////////////////////////////////////////////////////////////
   a_read_answer: assert property (cpu_rsp_o.rvalid == req_q.rd)
      else $error("read answer timing wrong");
   a_byte_high_zero: assert property (cpu_rsp_o.rvalid && !req_q.word |-> cpu_rsp_o.rdata[15:8] == 8'h00)
      else $error("byte read upper half not zero");
   a_low_bits_zero: assert property (
      cpu_rsp_o.rvalid && req_q.addr < ADDR_CSR && (req_q.word || req_q.addr[0])
      |-> cpu_rsp_o.rdata[5:0] == 6'h00)
      else $error("result low bits not zero");
   // sample pulse and busy rise on the same edge
   a_sample_follows: assert property ($rose(conv_busy_o) |-> core_sample_o)
      else $error("no sample after start");
   a_sample_pulse: assert property (core_sample_o |-> conv_busy_o ##1 !core_sample_o)
      else $error("sample pulse outside conversion");
   // aborts by write or standby are left out: they end early on purpose
   a_single_length: assert property (
      $fell(conv_busy_o) && !req_q.wr && !$past(cpu_req_i.wr, 2) && !$past(standby_i)
      && !$past(standby_i, 2) |-> len_q == 8'h46 || len_q == 8'h86)
      else $error("conversion length wrong");
   a_chan_held: assert property (core_sample_o |=> $stable(core_chan_o) [*8])
      else $error("channel moved during conversion");
   a_irq_cause: assert property (
      $rose(conv_end_irq_o) |-> $past(conv_busy_o) || req_q.wr || $past(cpu_req_i.wr, 2))
      else $error("interrupt raised without cause");
   a_irq_clear: assert property ($fell(conv_end_irq_o) |-> req_q.wr || $past(cpu_req_i.wr, 2))
      else $error("interrupt dropped without write");
   c_irq: cover property ($rose(conv_end_irq_o));
   c_word: cover property (cpu_rsp_o.rvalid && req_q.word);
   c_slow: cover property ($fell(conv_busy_o) && len_q == 8'h86);
endmodule

// file: tb/adcrc_core_model.sv
// converter core stand-in: result carries channel and a bench-chosen pattern
`timescale 1ns/10ps
module adcrc_core_model
(
   // sequencer side
   input  wire logic [2:0] chan_i,
   input  wire logic       busy_i,
   input  wire logic [6:0] bias_i,
   output      logic [9:0] result_o
);
   // inverted while idle so a stale capture never matches
   assign result_o = busy_i ? {chan_i, bias_i} : ~{chan_i, bias_i};
endmodule

// file: tb/adcrc_top_tb.sv
// testbench: register access, single, scan, latch and trigger runs
`timescale 1ns/10ps
module adcrc_top_tb;
   import adcrc_pkg::*;
   logic           clk_i = 1'b0;
   logic           rst_i = 1'b1;
   adcrc_cpu_req_t cpu_req_i = '0;
   adcrc_cpu_rsp_t cpu_rsp_o;
   logic [9:0]     core_result_i;
   logic [2:0]     core_chan_o;
   logic           core_sample_o, conv_busy_o, conv_end_irq_o;
   logic           standby_i = 1'b0;
   logic           ext_trigger_input_i = 1'b0;
   logic           ext_trigger_rising_i = 1'b1;
   logic [6:0]     bias = 7'h15;
   logic [15:0]    got;
   int             mismatches = 0;
   int             samples_checked = 0;
   always #5 clk_i = ~clk_i;
   adcrc_top u_dut (.clk_i, .rst_i, .cpu_req_i, .cpu_rsp_o, .core_result_i, .core_chan_o, .core_sample_o,
      .conv_busy_o, .standby_i, .ext_trigger_input_i, .ext_trigger_rising_i, .conv_end_irq_o);
   adcrc_core_model u_core (.chan_i(core_chan_o), .busy_i(conv_busy_o), .bias_i(bias), .result_o(core_result_i));
   ////////////////////////////////////////////////////////////////
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      samples_checked++;
      if (g !== e)
      begin
         mismatches++;
         $display("BAD %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic acc(input logic r, input logic w, input logic [3:0] a, input logic [7:0] d);
      @(negedge clk_i);
      cpu_req_i = '{r, ~r, w, a, d};
      @(negedge clk_i);
      cpu_req_i = '0;
      got = cpu_rsp_o.rdata;
   endtask
   task automatic wait_idle;
      @(negedge clk_i);
      repeat (300) if (conv_busy_o === 1'b1) @(negedge clk_i);
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////
   task automatic t_reset;
      acc(1'b0, 1'b0, 4'h0, 8'hFF);
      for (int i = 0; i < 8; i += 2)
      begin
         acc(1'b1, 1'b1, 4'(i), 8'h00);
         chk("result", 16'h0000, got);
      end
      acc(1'b1, 1'b0, ADDR_CSR, 8'h00);
      chk("csr", 16'h0000, got);
      acc(1'b1, 1'b0, 4'hA, 8'h00);
      chk("unmapped", 16'h0000, got);
   endtask
   task automatic t_single;
      logic [7:0] c;
      for (int ch = 0; ch < 8; ch++)
      begin
         c = 8'(ch) | (ch[0] ? 8'h08 : 8'h00);
         bias = 7'(ch * 9);
         acc(1'b0, 1'b0, ADDR_CSR, c | 8'h60);
         wait_idle();
         chk("irq", 16'h0001, 16'(conv_end_irq_o));
         acc(1'b0, 1'b0, ADDR_CSR, c);
         acc(1'b1, 1'b0, ADDR_CSR, 8'h00);
         chk("csr_done", {8'h00, c | 8'h80}, got);
         acc(1'b0, 1'b0, ADDR_CSR, c);
         acc(1'b0, 1'b0, ADDR_CSR, c | 8'h80);
         acc(1'b1, 1'b0, ADDR_CSR, 8'h00);
         chk("csr_clr", {8'h00, c}, got);
         acc(1'b1, 1'b1, 4'(ch % 4 * 2), 8'h00);
         chk("result", {3'(ch), bias, 6'h00}, got);
      end
   endtask
   task automatic t_latch;
      logic [9:0] v;
      v = {3'd4, 7'h24};
      acc(1'b1, 1'b0, 4'h0, 8'h00);
      chk("hi", {8'h00, v[9:2]}, got);
      bias = 7'h7F;
      acc(1'b0, 1'b0, ADDR_CSR, 8'h28);
      wait_idle();
      chk("irq_off", 16'h0000, 16'(conv_end_irq_o));
      acc(1'b1, 1'b0, 4'h1, 8'h00);
      chk("lo_latched", {8'h00, v[1:0], 6'h00}, got);
      acc(1'b1, 1'b0, 4'h0, 8'h00);
      acc(1'b1, 1'b0, 4'h1, 8'h00);
      chk("lo_new", 16'h00C0, got);
   endtask
   task automatic t_scan;
      int gap;
      acc(1'b1, 1'b0, ADDR_CSR, 8'h00);
      acc(1'b0, 1'b0, ADDR_CSR, 8'h00);
      bias = 7'h33;
      acc(1'b0, 1'b0, ADDR_CSR, 8'h3E);
      for (int k = 0; k < 4; k++)
      begin
         gap = 0;
         do
         begin
            @(negedge clk_i);
            gap++;
         end
         while (core_sample_o !== 1'b1 && gap < 300);
         chk("chan", 16'(3'd4 + 3'(k % 3)), 16'(core_chan_o));
         if (k > 0)
            chk("gap", (k == 1) ? 16'(FIRST_FAST_STATES) : 16'(NEXT_FAST_STATES), 16'(gap));
      end
      acc(1'b1, 1'b0, ADDR_CSR, 8'h00);
      chk("scan_csr", 16'h00BE, got);
      acc(1'b1, 1'b1, 4'h2, 8'h00);
      chk("scan_res", {3'd5, 7'h33, 6'h00}, got);
      acc(1'b0, 1'b0, ADDR_CSR, 8'h1E);
      chk("stopped", 16'h0000, 16'(conv_busy_o));
      acc(1'b0, 1'b0, ADDR_CSR, 8'h3E);
      repeat (5) @(negedge clk_i);
      standby_i = 1'b1;
      repeat (2) @(negedge clk_i);
      standby_i = 1'b0;
      acc(1'b1, 1'b0, ADDR_CSR, 8'h00);
      chk("standby", 16'h0000, got & 16'h0020);
   endtask
   task automatic t_trig;
      acc(1'b0, 1'b0, ADDR_CSR, 8'h0C);
      acc(1'b0, 1'b0, ADDR_TRG_CTRL, 8'h80);
      acc(1'b1, 1'b0, ADDR_TRG_CTRL, 8'h00);
      chk("trg_ctrl", 16'h00FE, got);
      ext_trigger_input_i = 1'b1;
      repeat (3) @(negedge clk_i);
      chk("trg_busy", 16'h0001, 16'(conv_busy_o));
      wait_idle();
      // falling-edge select, changed while the pin is high so no false edge
      ext_trigger_rising_i = 1'b0;
      @(negedge clk_i);
      ext_trigger_input_i = 1'b0;
      repeat (3) @(negedge clk_i);
      chk("trg_fall_busy", 16'h0001, 16'(conv_busy_o));
      wait_idle();
   endtask
   initial
   begin
      repeat (3) @(negedge clk_i);
      rst_i = 1'b0;
      t_reset();
      t_single();
      t_latch();
      t_scan();
      t_trig();
      close_out();
   end
   initial
   begin
      #100000;
      mismatches++;
      close_out();
   end
endmodule
bind adcrc_top adcrc_sva u_sva (.clk_i, .rst_i, .cpu_req_i, .cpu_rsp_o, .core_chan_o, .core_sample_o,
   .conv_busy_o, .standby_i, .conv_end_irq_o);
